/* core/dscb_bank.sv */
// What this block does
// - In frequency mode, duty equals measured frequency over the 15-bit full-scale setting.
// - Current gain enable makes the current amplifier re-tune every 1ms.
// - Voltage gain enable makes the voltage measurement re-tune every 1ms.
// - Clock source code 0 internal, 1 crude oscillator, 3 external, 2 reserved.
// - External reference mode only while its enable bit is set.
// - Reference rate field gives 8 kHz doubling per code to 1024 kHz.
// - Watchdog supervises the host only while its enable is set.
// - Tickle interval 100 to 1000 ms on pin, 1 to 10 s on bus.
// - Tickle source is the serial bus when clear, general pin when set.
// - Timeout only reports when action bit clear, else latches and floats outputs.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module dscb_bank #(
	parameter logic [3:0][31:0] SLEEP_CYC_P   = dscb_pkg::SLEEP_CYC,
	parameter logic [31:0]      GAIN_CYC_P    = dscb_pkg::GAIN_CYC,
	parameter logic [3:0][31:0] WDT_PIN_CYC_P = dscb_pkg::WDT_PIN_CYC,
	parameter logic [3:0][31:0] WDT_BUS_CYC_P = dscb_pkg::WDT_BUS_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic [31:0]      regRdData,
	// Speed input, from logic on this clock
	input  wire logic        freqModeActive,
	input  wire logic [14:0] measuredFreq,
	input  wire logic        speedBelowThreshold,
	// Watchdog tickles
	input  wire logic        busTickle,
	input  wire logic        tickPin,
	// Speed and power
	output logic [15:0]      dutyCmd,
	output logic             dutyValid,
	output logic             sleepReq,
	output logic             standbyReq,
	// Gain tuning
	output logic             currentGainTick,
	output logic             voltageGainTick,
	// Clocking
	output logic [1:0]       clkSourceSel,
	output logic             extRefActive,
	output logic [10:0]      extRefRateKhz,
	// Watchdog results
	output logic             wdtFaultReport,
	output logic             wdtFaultLatched,
	output logic             outputsHiZ,
	// Peripheral setup word
	output logic [31:0]      periSetup
);
	import dscb_pkg::*;

	logic [31:0] devSetupTwo_r;
	logic [31:0] periSetupOne_r;
	logic        timeoutSeen_r;
	logic        faultLatch_r;
	logic [31:0] sleepCnt_r;
	logic        belowHit_r;
	logic [31:0] gainCnt_r;
	logic        tickMeta_r;
	logic        tickSync_r;
	logic        tickPrev_r;
	logic        divBusy_r;
	logic        divDone;
	logic [15:0] divQuot;
	logic        wdtTimeout;

	// Address decode
	wire selDev2   = regAddr == ADDR_DEV_SETUP_TWO;
	wire selPeri   = regAddr == ADDR_PERI_SETUP_ONE;
	wire selStatus = regAddr == ADDR_STATUS;
	wire wrDev2    = regWrEn && selDev2;
	wire wrPeri    = regWrEn && selPeri;
	wire wrStatus  = regWrEn && selStatus;

	// Field views of device_setup_two
	wire [14:0] maxFreq          = devSetupTwo_r[MAX_FREQ_MSB:MAX_FREQ_LSB];
	wire [1:0]  sleepEntrySel    = devSetupTwo_r[SLEEP_TIME_LSB +: 2];
	wire        autoCurGainEn    = devSetupTwo_r[CUR_GAIN_BIT];
	wire        autoVoltGainEn   = devSetupTwo_r[VOLT_GAIN_BIT];
	wire        lowPowerKindSel  = devSetupTwo_r[LOW_POWER_BIT];
	wire [1:0]  clkSelField      = devSetupTwo_r[CLK_SEL_LSB +: 2];
	wire        extRefEnable     = devSetupTwo_r[EXT_REF_EN_BIT];
	wire [2:0]  extRefRate       = devSetupTwo_r[EXT_RATE_LSB +: 3];
	wire        hostWdtEnable    = devSetupTwo_r[WDT_EN_BIT];
	wire [1:0]  hostWdtInterval  = devSetupTwo_r[WDT_IVL_LSB +: 2];
	wire        hostWdtSource    = devSetupTwo_r[WDT_SRC_BIT];
	wire        hostWdtFaultAct  = devSetupTwo_r[WDT_ACT_BIT];

	// Status word, with the duty readback in the upper half
	wire [31:0] statusWord = {dutyCmd, 11'h000, extRefActive, standbyReq, sleepReq,
		faultLatch_r, timeoutSeen_r};

	// Reads of unmapped addresses return zero
	wire [31:0] rdMux = selDev2   ? devSetupTwo_r :
	                    selPeri   ? periSetupOne_r :
	                    selStatus ? statusWord : 32'h0000_0000;

	wire [1:0] clkSelEff = (clkSelField == CLK_CRUDE)    ? CLK_CRUDE :
	                       (clkSelField == CLK_EXTERNAL) ? CLK_EXTERNAL : CLK_INTERNAL;

	wire [10:0] rateKhz = EXT_RATE_BASE_KHZ << extRefRate;

	wire [31:0] sleepLimit = SLEEP_CYC_P[sleepEntrySel];
	wire        sleepDone  = sleepCnt_r >= sleepLimit - 32'd1;

	wire gainTickNow = gainCnt_r >= GAIN_CYC_P - 32'd1;

	// Pin tickle after two flip-flops, rising edge only
	wire pinTickle = tickSync_r && !tickPrev_r;

	wire selTickle = hostWdtSource ? pinTickle : busTickle;

	wire [31:0] wdtLimit = hostWdtSource ? WDT_PIN_CYC_P[hostWdtInterval] : WDT_BUS_CYC_P[hostWdtInterval];

	// restart the divider whenever it is idle in frequency mode
	wire divStart = freqModeActive && !divBusy_r;

	// Status clears are write one to clear
	wire clrTimeout = wrStatus && regWrData[ST_TIMEOUT_BIT];
	wire clrLatch   = wrStatus && regWrData[ST_LATCH_BIT];

	wire setTimeout = wdtTimeout;
	wire setLatch   = wdtTimeout && hostWdtFaultAct;

	dscb_div u_div (
		.clk    (clk),
		.resetn (resetn),
		.start  (divStart),
		.numer  (measuredFreq),
		.denom  (maxFreq),
		.done   (divDone),
		.quot   (divQuot)
	);

	dscb_wdt u_wdt (
		.clk     (clk),
		.resetn  (resetn),
		.enable  (hostWdtEnable),
		.limit   (wdtLimit),
		.tickle  (selTickle),
		.timeout (wdtTimeout)
	);

	// Register storage, bit 31 never stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			devSetupTwo_r <= RST_DEV_SETUP_TWO;
		else if (wrDev2)
			devSetupTwo_r <= regWrData & MASK_DEV_SETUP_TWO;
	end

	// Peripheral word is stored only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			periSetupOne_r <= RST_PERI_SETUP_ONE;
		else if (wrPeri)
			periSetupOne_r <= regWrData;
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			regRdData <= '0;
		else
			regRdData <= regRdEn ? rdMux : 32'h0000_0000;
	end

	// Sticky timeout flag, a new event beats a clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			timeoutSeen_r <= 1'b0;
		else
			timeoutSeen_r <= setTimeout || (timeoutSeen_r && !clrTimeout);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			faultLatch_r <= 1'b0;
		else
			faultLatch_r <= setLatch || (faultLatch_r && !clrLatch);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			wdtFaultReport <= 1'b0;
		else
			wdtFaultReport <= setTimeout;
	end

	// latched fault, same cycle as the flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			wdtFaultLatched <= 1'b0;
		else
			wdtFaultLatched <= setLatch || (faultLatch_r && !clrLatch);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			outputsHiZ <= 1'b0;
		else
			outputsHiZ <= setLatch || (faultLatch_r && !clrLatch);
	end

	// Pin synchroniser, the first stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tickMeta_r <= 1'b0;
			tickSync_r <= 1'b0;
			tickPrev_r <= 1'b0;
		end else begin
			tickMeta_r <= tickPin;
			tickSync_r <= tickMeta_r;
			tickPrev_r <= tickSync_r;
		end
	end

	// divider busy until its result lands
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			divBusy_r <= 1'b0;
		else if (divStart)
			divBusy_r <= 1'b1;
		else if (divDone)
			divBusy_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			dutyCmd <= '0;
		else if (divDone && freqModeActive)
			dutyCmd <= divQuot;
	end

	// valid from the first result on, cleared when frequency mode ends
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			dutyValid <= 1'b0;
		else
			dutyValid <= freqModeActive && (dutyValid || divDone);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleepCnt_r <= '0;
			belowHit_r <= 1'b0;
		end else begin
			if (!speedBelowThreshold) begin
				sleepCnt_r <= '0;
				belowHit_r <= 1'b0;
			end else if (sleepDone) begin
				belowHit_r <= 1'b1;
			end else begin
				sleepCnt_r <= sleepCnt_r + 32'd1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sleepReq <= 1'b0;
		else
			sleepReq <= belowHit_r && lowPowerKindSel;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			standbyReq <= 1'b0;
		else
			standbyReq <= belowHit_r && !lowPowerKindSel;
	end

	// Free running, so both re-tune ticks stay aligned
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			gainCnt_r <= '0;
		else
			gainCnt_r <= gainTickNow ? 32'd0 : gainCnt_r + 32'd1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			currentGainTick <= 1'b0;
		else
			currentGainTick <= gainTickNow && autoCurGainEn;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			voltageGainTick <= 1'b0;
		else
			voltageGainTick <= gainTickNow && autoVoltGainEn;
	end

	// reserved code falls back to internal
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			clkSourceSel <= CLK_INTERNAL;
		else
			clkSourceSel <= clkSelEff;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			extRefActive <= 1'b0;
		else
			extRefActive <= extRefEnable;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			extRefRateKhz <= EXT_RATE_BASE_KHZ;
		else
			extRefRateKhz <= rateKhz;
	end

	// Peripheral copy, one cycle behind the register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			periSetup <= RST_PERI_SETUP_ONE;
		else
			periSetup <= periSetupOne_r;
	end
endmodule : dscb_bank
`default_nettype wire

/* include/dscb_pkg.sv */
`default_nettype none
package dscb_pkg;
	// Register map on the plain register port
	localparam logic [7:0]  ADDR_DEV_SETUP_TWO  = 8'ha8;
	localparam logic [7:0]  ADDR_PERI_SETUP_ONE = 8'haa;
	localparam logic [7:0]  ADDR_STATUS         = 8'hb0;
	localparam logic [31:0] RST_DEV_SETUP_TWO   = 32'h0000_0000;
	localparam logic [31:0] RST_PERI_SETUP_ONE  = 32'h0400_0000;
	localparam logic [31:0] MASK_DEV_SETUP_TWO  = 32'h7fff_ffff;
	// Field positions of device_setup_two
	localparam int MAX_FREQ_LSB   = 16;
	localparam int MAX_FREQ_MSB   = 30;
	localparam int SLEEP_TIME_LSB = 14;
	localparam int CUR_GAIN_BIT   = 13;
	localparam int VOLT_GAIN_BIT  = 12;
	localparam int LOW_POWER_BIT  = 11;
	localparam int CLK_SEL_LSB    = 9;
	localparam int EXT_REF_EN_BIT = 8;
	localparam int EXT_RATE_LSB   = 5;
	localparam int WDT_EN_BIT     = 4;
	localparam int WDT_IVL_LSB    = 2;
	localparam int WDT_SRC_BIT    = 1;
	localparam int WDT_ACT_BIT    = 0;
	// Status register fields
	localparam int ST_TIMEOUT_BIT = 0;
	localparam int ST_LATCH_BIT   = 1;
	localparam int ST_SLEEP_BIT   = 2;
	localparam int ST_STANDBY_BIT = 3;
	localparam int ST_EXTREF_BIT  = 4;
	localparam int ST_DUTY_LSB    = 16;
	// Clock source codes
	localparam logic [1:0] CLK_INTERNAL = 2'h0;
	localparam logic [1:0] CLK_CRUDE    = 2'h1;
	localparam logic [1:0] CLK_EXTERNAL = 2'h3;
	// External reference rate at code 0, doubling per code
	localparam logic [10:0] EXT_RATE_BASE_KHZ = 11'h008;
	localparam logic [15:0] DUTY_FULL         = 16'h8000;
	// Timing, figures in their own units
	localparam longint CLK_MHZ       = 250;
	localparam longint CYC_PER_MS    = CLK_MHZ * 1000;
	localparam longint GAIN_TIME_MS  = 1;
	localparam longint SLEEP_US [4]  = '{50, 200, 20000, 200000};
	localparam longint WDT_PIN_MS [4] = '{100, 200, 500, 1000};
	localparam longint WDT_BUS_S [4]  = '{1, 2, 5, 10};
	localparam logic [31:0] GAIN_CYC = 32'(GAIN_TIME_MS * CYC_PER_MS);
	localparam logic [3:0][31:0] SLEEP_CYC = {32'(SLEEP_US[3] * CLK_MHZ), 32'(SLEEP_US[2] * CLK_MHZ),
		32'(SLEEP_US[1] * CLK_MHZ), 32'(SLEEP_US[0] * CLK_MHZ)};
	localparam logic [3:0][31:0] WDT_PIN_CYC = {32'(WDT_PIN_MS[3] * CYC_PER_MS), 32'(WDT_PIN_MS[2] * CYC_PER_MS),
		32'(WDT_PIN_MS[1] * CYC_PER_MS), 32'(WDT_PIN_MS[0] * CYC_PER_MS)};
	localparam logic [3:0][31:0] WDT_BUS_CYC = {32'(WDT_BUS_S[3] * 1000 * CYC_PER_MS),
		32'(WDT_BUS_S[2] * 1000 * CYC_PER_MS), 32'(WDT_BUS_S[1] * 1000 * CYC_PER_MS),
		32'(WDT_BUS_S[0] * 1000 * CYC_PER_MS)};
	// Divider states
	typedef enum logic [2:0] {
		DIV_IDLE = 3'b001,
		DIV_RUN  = 3'b010,
		DIV_DONE = 3'b100
	} dscb_div_state_t;
	localparam logic [4:0] DIV_STEPS = 5'd30;
endpackage : dscb_pkg
`default_nettype wire

/* core/dscb_div.sv */
`default_nettype none
module dscb_div (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Request
	input  wire logic        start,
	input  wire logic [14:0] numer,
	input  wire logic [14:0] denom,
	// Result
	output logic             done,
	output logic [15:0]      quot
);
	import dscb_pkg::*;

	dscb_div_state_t state_r, state_nxt;
	logic [29:0] quo_r;
	logic [15:0] rem_r;
	logic [14:0] den_r;
	logic [4:0]  step_r;
	wire  [15:0] remSh   = {rem_r[14:0], quo_r[29]};
	wire         fits    = remSh >= {1'b0, den_r};
	wire  [15:0] remNext = fits ? remSh - {1'b0, den_r} : remSh;
	// Above full scale is clamped, a zero scale counts as full scale
	wire  [15:0] clamped = (|quo_r[29:16] || quo_r[15:0] > DUTY_FULL) ? DUTY_FULL : quo_r[15:0];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DIV_IDLE: if (start) state_nxt = DIV_RUN;
			DIV_RUN:  if (step_r == DIV_STEPS - 5'd1) state_nxt = DIV_DONE;
			DIV_DONE: state_nxt = DIV_IDLE;
			default:  state_nxt = DIV_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= DIV_IDLE;
			quo_r   <= '0;
			rem_r   <= '0;
			den_r   <= '0;
			step_r  <= '0;
			done    <= 1'b0;
			quot    <= '0;
		end else begin
			state_r <= state_nxt;
			done    <= state_r == DIV_DONE;
			if (state_r == DIV_IDLE && start) begin
				quo_r  <= {numer, 15'h0000};
				rem_r  <= '0;
				den_r  <= denom;
				step_r <= '0;
			end else if (state_r == DIV_RUN) begin
				quo_r  <= {quo_r[28:0], fits};
				rem_r  <= remNext;
				step_r <= step_r + 5'd1;
			end
			if (state_r == DIV_DONE)
				quot <= (den_r == 15'h0000) ? ((|quo_r) ? DUTY_FULL : 16'h0000) : clamped;
		end
	end
endmodule : dscb_div
`default_nettype wire

/* core/dscb_wdt.sv */
`default_nettype none
module dscb_wdt (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Control
	input  wire logic        enable,
	input  wire logic [31:0] limit,
	input  wire logic        tickle,
	// Expiry
	output logic             timeout
);
	logic [31:0] cnt_r;
	logic        enPrev_r;
	wire restart = tickle || (enable && !enPrev_r);
	wire expire  = enable && !restart && (cnt_r >= limit - 32'd1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r    <= '0;
			enPrev_r <= 1'b0;
			timeout  <= 1'b0;
		end else begin
			enPrev_r <= enable;
			timeout  <= expire;
			if (!enable || restart || expire)
				cnt_r <= '0;
			else
				cnt_r <= cnt_r + 32'd1;
		end
	end
endmodule : dscb_wdt
`default_nettype wire

/* tb/dscb_bank_properties.sv */
`default_nettype none
module dscb_bank_properties (
	// Watched ports
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        freqModeActive,
	input wire logic        speedBelowThreshold,
	input wire logic [15:0] dutyCmd,
	input wire logic        dutyValid,
	input wire logic        sleepReq,
	input wire logic        standbyReq,
	input wire logic        currentGainTick,
	input wire logic        voltageGainTick,
	input wire logic [1:0]  clkSourceSel,
	input wire logic [10:0] extRefRateKhz,
	input wire logic        wdtFaultReport,
	input wire logic        wdtFaultLatched,
	input wire logic        outputsHiZ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_duty_clamp: assert property (dutyCmd <= 16'h8000)
		else $error("duty above full scale");
	chk_duty_valid: assert property ($rose(dutyValid) |-> $past(freqModeActive))
		else $error("duty valid outside frequency mode");
	chk_sleep_excl: assert property (!(sleepReq && standbyReq))
		else $error("sleep and standby together");
	chk_sleep_cause: assert property ($rose(sleepReq || standbyReq) |-> $past(speedBelowThreshold, 2))
		else $error("low power request without low speed");
	chk_cur_pulse: assert property ($rose(currentGainTick) |=> $fell(currentGainTick))
		else $error("current gain tick too long");
	chk_volt_gap: assert property (voltageGainTick |=> !voltageGainTick [*8])
		else $error("voltage gain ticks too close");
	chk_clk_code: assert property (clkSourceSel != 2'h2)
		else $error("reserved clock source driven");
	chk_rate_pow: assert property ($onehot(extRefRateKhz) && extRefRateKhz >= 11'h008)
		else $error("reference rate not a doubling of base");
	chk_hiz_latch: assert property (outputsHiZ == wdtFaultLatched)
		else $error("high impedance differs from latch");
	chk_latch_cause: assert property ($rose(wdtFaultLatched) |-> wdtFaultReport)
		else $error("latch without timeout");
	cov_report: cover property (wdtFaultReport);
	cov_sleep: cover property (sleepReq);
	cov_latch: cover property (wdtFaultLatched);
endmodule : dscb_bank_properties
bind dscb_bank dscb_bank_properties chk_u (.clk, .resetn, .freqModeActive, .speedBelowThreshold, .dutyCmd,
	.dutyValid, .sleepReq, .standbyReq, .currentGainTick, .voltageGainTick, .clkSourceSel, .extRefRateKhz,
	.wdtFaultReport, .wdtFaultLatched, .outputsHiZ);
`default_nettype wire

/* tb/dscb_host.sv */
`default_nettype none
module dscb_host (
	// Clock, reset, commands
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       run,
	input  wire logic       viaPin,
	input  wire logic [7:0] gap,
	// Tickles
	output logic            busTickle,
	output logic            tickPin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
			busTickle <= 1'b0;
			tickPin <= 1'b0;
		end else begin
			busTickle <= 1'b0;
			cnt_r <= (cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
			// Pin toggles, so a rising edge comes every second wrap
			if (run && cnt_r >= gap) begin
				if (viaPin)
					tickPin <= !tickPin;
				else
					busTickle <= 1'b1;
			end
		end
	end
endmodule : dscb_host
`default_nettype wire

/* tb/dscb_bank_tb_top.sv */
`default_nettype none
module dscb_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dscb_pkg::*;
	// Shortened counts
	localparam logic [3:0][31:0] SLP = {32'h28, 32'h1e, 32'h14, 32'h0a};
	localparam logic [3:0][31:0] PIN = {32'h50, 32'h3c, 32'h28, 32'h14};
	localparam logic [3:0][31:0] BUS = {32'ha0, 32'h78, 32'h64, 32'h32};
	logic        clk, resetn, regWrEn, regRdEn, freqModeActive, speedBelowThreshold, busTickle, tickPin;
	logic        run, viaPin, dutyValid, sleepReq, standbyReq, currentGainTick, voltageGainTick;
	logic        extRefActive, wdtFaultReport, wdtFaultLatched, outputsHiZ;
	logic [7:0]  regAddr, gap;
	logic [31:0] regWrData, regRdData, periSetup;
	logic [14:0] measuredFreq;
	logic [15:0] dutyCmd;
	logic [1:0]  clkSourceSel;
	logic [10:0] extRefRateKhz;
	int          errors, n_tests, nCur, nVol, nRep, cycles;
	dscb_bank #(.SLEEP_CYC_P(SLP), .GAIN_CYC_P(32'h10), .WDT_PIN_CYC_P(PIN), .WDT_BUS_CYC_P(BUS)) dut_u (
		.clk, .resetn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .freqModeActive, .measuredFreq,
		.speedBelowThreshold, .busTickle, .tickPin, .dutyCmd, .dutyValid, .sleepReq, .standbyReq,
		.currentGainTick, .voltageGainTick, .clkSourceSel, .extRefActive, .extRefRateKhz, .wdtFaultReport,
		.wdtFaultLatched, .outputsHiZ, .periSetup);
	dscb_host host_u (.clk, .resetn, .run, .viaPin, .gap, .busTickle, .tickPin);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		nCur += int'(currentGainTick === 1'b1);
		nVol += int'(voltageGainTick === 1'b1);
		nRep += int'(wdtFaultReport === 1'b1);
		cycles++;
		// Whole run is about 1200 cycles
		if (cycles == 10000) begin
			errors++;
			results();
		end
	end
	task automatic results();
		$display("Checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// Derived outputs settle one edge after the write lands
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		cyc(2);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] d;
		rd(a, d);
		chk(nm, d, exp);
	endtask : rc
	initial begin
		int a;
		int b;
		logic [31:0] d;
		{regWrEn, regRdEn, freqModeActive, speedBelowThreshold, run, viaPin} = 6'h00;
		{regAddr, gap, regWrData, measuredFreq} = '0;
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rc(ADDR_DEV_SETUP_TWO, RST_DEV_SETUP_TWO, "setup_two");
		rc(ADDR_PERI_SETUP_ONE, RST_PERI_SETUP_ONE, "peri_one");
		chk("periSetup", periSetup, RST_PERI_SETUP_ONE);
		chk("rate", 32'(extRefRateKhz), 32'h8);
		wr(ADDR_DEV_SETUP_TWO, 32'hffff_ffff);
		rc(ADDR_DEV_SETUP_TWO, MASK_DEV_SETUP_TWO, "top bit");
		wr(8'h10, 32'h1234_5678);
		rc(8'h10, 32'h0, "unmapped");
		wr(ADDR_PERI_SETUP_ONE, 32'h0123_4567);
		rc(ADDR_PERI_SETUP_ONE, 32'h0123_4567, "peri_one rw");
		chk("periSetup", periSetup, 32'h0123_4567);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_DEV_SETUP_TWO, 32'((i << 5) | ((i % 4) << 9) | ((i % 2) << 8)));
			chk("clkSel", 32'(clkSourceSel), 32'((i % 4 == 2) ? 0 : i % 4));
			chk("extRef", 32'(extRefActive), 32'(i % 2));
			chk("rate", 32'(extRefRateKhz), 32'(8 << i));
		end
		for (int j = 0; j < 2; j++) begin
			wr(ADDR_DEV_SETUP_TWO, j ? 32'h0000_1000 : 32'h0000_3000);
			a = nCur;
			b = nVol;
			cyc(64);
			chk("curTick", 32'(nCur - a), j ? 32'h0 : 32'h4);
			chk("voltTick", 32'(nVol - b), 32'h4);
		end
		for (int j = 0; j < 2; j++) begin
			wr(ADDR_DEV_SETUP_TWO, j ? 32'h0800_0000 : 32'h2000_0000);
			@(posedge clk);
			measuredFreq <= 15'h1000;
			freqModeActive <= 1'b1;
			cyc(80);
			chk("dutyValid", 32'(dutyValid), 32'h1);
			chk("duty", 32'(dutyCmd), j ? 32'h8000 : 32'h4000);
			rc(ADDR_STATUS, j ? 32'h8000_0000 : 32'h4000_0000, "dutyRead");
		end
		@(posedge clk);
		freqModeActive <= 1'b0;
		for (int j = 0; j < 2; j++) begin
			wr(ADDR_DEV_SETUP_TWO, j ? 32'h0000_0000 : 32'h0000_4800);
			@(posedge clk);
			speedBelowThreshold <= 1'b1;
			cyc(j ? 8 : 18);
			chk("early", 32'(sleepReq | standbyReq), 32'h0);
			cyc(6);
			chk("sleepReq", 32'(sleepReq), 32'(1 - j));
			chk("standbyReq", 32'(standbyReq), 32'(j));
			rd(ADDR_STATUS, d);
			chk("stLow", 32'(d[3:2]), j ? 32'h2 : 32'h1);
			@(posedge clk);
			speedBelowThreshold <= 1'b0;
			cyc(3);
			chk("wake", 32'(sleepReq | standbyReq), 32'h0);
		end
		wr(ADDR_STATUS, 32'h3);
		a = nRep;
		cyc(200);
		chk("off", 32'(nRep - a), 32'h0);
		@(posedge clk);
		run <= 1'b1;
		gap <= 8'h1d;
		wr(ADDR_DEV_SETUP_TWO, 32'h0000_0010);
		a = nRep;
		cyc(200);
		chk("tickled", 32'(nRep - a), 32'h0);
		// Pin tickles must not count while the bus is selected
		@(posedge clk);
		viaPin <= 1'b1;
		gap <= 8'h09;
		a = nRep;
		cyc(60);
		chk("timeout", 32'(nRep - a), 32'h1);
		wr(ADDR_DEV_SETUP_TWO, 32'h0000_0000);
		rd(ADDR_STATUS, d);
		chk("seen", 32'(d[1:0]), 32'h1);
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, d);
		chk("cleared", 32'(d[1:0]), 32'h0);
		wr(ADDR_DEV_SETUP_TWO, 32'h0000_0017);
		cyc(200);
		chk("pinOk", 32'(wdtFaultLatched), 32'h0);
		@(posedge clk);
		run <= 1'b0;
		cyc(20);
		chk("notYet", 32'(wdtFaultLatched), 32'h0);
		cyc(40);
		chk("latched", 32'(wdtFaultLatched), 32'h1);
		chk("hiZ", 32'(outputsHiZ), 32'h1);
		wr(ADDR_DEV_SETUP_TWO, 32'h0000_0000);
		wr(ADDR_STATUS, 32'h2);
		chk("unlatch", 32'(wdtFaultLatched), 32'h0);
		results();
	end
endmodule : dscb_bank_tb_top
`default_nettype wire
